// File: inc/mras_pkg.sv
// constants and types of the management frame register access slave
package mras_pkg;

   // ****************************************************************
   // frame format
   // ****************************************************************
   localparam int DATA_W = 16;
   localparam int CFG_DATA_W = 8;
   localparam int PREAMBLE_LEN = 32;
   localparam logic [5:0] PRE_CNT_FULL = 6'(PREAMBLE_LEN);
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_CFG = 2'h0;
   localparam logic [1:0] OP_BAD = 2'h3;
   localparam logic [1:0] TA_WRITE = 2'h2;
   localparam logic [4:0] OP_LAST = 5'h01;
   localparam logic [4:0] FIELD_LAST = 5'h04;
   localparam logic [4:0] TA_LAST = 5'h01;
   localparam logic [4:0] DATA_LAST = 5'h0f;

   // ****************************************************************
   // address decoding
   // ****************************************************************
   localparam int CFG_SEL_BIT = 4;
   localparam logic [7:0] CFG_ADDR_MAX = 8'hc6;
   localparam logic [4:0] PHY_STD_LAST = 5'h05;
   localparam logic [4:0] PHY_CUST_LO = 5'h1d;
   localparam logic [4:0] PHY_CUST_HI = 5'h1f;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int MDC_MAX_HZ = 5000000;
   localparam int CORE_PERIOD_NS = 25;
   localparam int MDC_MIN_PERIOD_NS = 1000000000 / MDC_MAX_HZ;
   // core cycles from address capture to the data load, rounded down
   localparam int TA_WINDOW_CYC = (2 * MDC_MIN_PERIOD_NS) / CORE_PERIOD_NS;
   localparam int SYNC_OVERHEAD_CYC = 4;
   localparam int ANSWER_CYC = TA_WINDOW_CYC - SYNC_OVERHEAD_CYC;
   localparam logic [3:0] ANSWER_CNT = 4'(ANSWER_CYC);

   // ****************************************************************
   // types
   // ****************************************************************
   typedef struct packed {
      logic isCfg;
      logic write;
      logic [4:0] phyAddrField;
      logic [7:0] regAddr;
      logic [DATA_W-1:0] wdata;
   } mras_cmd_t;

   typedef enum logic [3:0] {
      LK_PRE,
      LK_START,
      LK_OP,
      LK_PHY,
      LK_REG,
      LK_TA_RD1,
      LK_TA_RD2,
      LK_RD,
      LK_TA_WR,
      LK_WR
   } mras_state_t;

endpackage

// File: design/mras_sync.sv
// two flip-flop synchroniser with asynchronous clear
`timescale 1ns/100ps
module mras_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mras_sync_t;

   mras_sync_t sync_reg;
   mras_sync_t sync_next;

   // first stage feeds only the second stage
   always_comb begin
      sync_next.s1 = d;
      sync_next.s2 = sync_reg.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg.s2;

endmodule

// File: design/mras_slave.sv
// management frame slave: standard and configuration register access
`timescale 1ns/100ps
module mras_slave (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic mdcClk,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   output logic cmdValid,
   output mras_pkg::mras_cmd_t cmd,
   input wire logic rdValid,
   input wire logic [mras_pkg::DATA_W-1:0] rdData
);

   // ****************************************************************
   // state of both domains
   // ****************************************************************
   typedef struct packed {
      mras_pkg::mras_state_t st;
      logic [5:0] preCnt;
      logic [4:0] bitCnt;
      logic [mras_pkg::DATA_W-1:0] sh;
      logic [1:0] op;
      logic [4:0] phy;
      logic [1:0] ta;
      logic hit;
      logic reqTgl;
      mras_pkg::mras_cmd_t cmd;
      logic mdioOut;
      logic mdioOe;
   } mras_link_t;

   typedef struct packed {
      logic seen;
      logic cmdValid;
      mras_pkg::mras_cmd_t cmd;
      logic [mras_pkg::DATA_W-1:0] rdHold;
      logic waiting;
      logic [3:0] waitCnt;
   } mras_core_t;

   mras_link_t link_reg;
   mras_link_t link_next;
   mras_core_t core_reg;
   mras_core_t core_next;

   logic linkRst_n;
   logic reqSync;
   logic reqEdge;
   logic [1:0] opWord;
   logic [1:0] taWord;
   logic [mras_pkg::DATA_W-1:0] shIn;
   logic cfgOp;
   logic rdOp;
   logic [7:0] frameAddr;
   logic frameHit;
   logic [mras_pkg::DATA_W-1:0] rdWord;

   // ****************************************************************
   // decoding
   // ****************************************************************
   function automatic logic isPhyReg(input logic [4:0] ra);
      isPhyReg = (ra <= mras_pkg::PHY_STD_LAST) || (ra == mras_pkg::PHY_CUST_LO) ||
                 (ra == mras_pkg::PHY_CUST_HI);
   endfunction

   function automatic logic cfgInRange(input logic [7:0] addr);
      cfgInRange = (addr <= mras_pkg::CFG_ADDR_MAX);
   endfunction

   // ****************************************************************
   // link domain reset: released on the management clock
   // ****************************************************************
   // the management clock may stop; the clear is immediate, the release clocked
   mras_sync #(.W(1)) u_link_rst (
      .clk(mdcClk),
      .rst_n(reset_n),
      .d(1'h1),
      .q(linkRst_n)
   );

   // ****************************************************************
   // link domain: frame decoder on the management clock
   // ****************************************************************
   // mdio is launched by the host off the same clock, so it is sampled directly
   assign opWord = {link_reg.op[0], mdioIn};
   assign taWord = {link_reg.ta[0], mdioIn};
   assign shIn = {link_reg.sh[mras_pkg::DATA_W-2:0], mdioIn};
   assign cfgOp = (link_reg.op == mras_pkg::OP_CFG);
   // bit 3 of the phy field never enters the decode
   assign rdOp = (link_reg.op == mras_pkg::OP_READ) ||
                 (cfgOp && link_reg.phy[mras_pkg::CFG_SEL_BIT]);
   assign frameAddr = cfgOp ? {link_reg.phy[2:0], shIn[4:0]} : {3'h0, shIn[4:0]};
   assign frameHit = cfgOp ? cfgInRange(frameAddr) : isPhyReg(shIn[4:0]);
   // rdHold has been stable since the core took the read answer or its wait count ran out
   assign rdWord = link_reg.hit ? core_reg.rdHold : '0;

   always_comb begin
      link_next = link_reg;
      unique case (link_reg.st)
         mras_pkg::LK_PRE: begin
            if (mdioIn) begin
               if (link_reg.preCnt != mras_pkg::PRE_CNT_FULL) begin
                  link_next.preCnt = link_reg.preCnt + 6'h01;
               end
            end else begin
               if (link_reg.preCnt == mras_pkg::PRE_CNT_FULL) begin
                  link_next.st = mras_pkg::LK_START;
               end
               link_next.preCnt = '0;
            end
         end
         mras_pkg::LK_START: begin
            link_next.bitCnt = mras_pkg::OP_LAST;
            link_next.st = mdioIn ? mras_pkg::LK_OP : mras_pkg::LK_PRE;
         end
         mras_pkg::LK_OP: begin
            link_next.op = opWord;
            link_next.bitCnt = link_reg.bitCnt - 5'h01;
            if (link_reg.bitCnt == '0) begin
               link_next.bitCnt = mras_pkg::FIELD_LAST;
               // opcode 11 names nothing; wait for a fresh preamble
               link_next.st = (opWord == mras_pkg::OP_BAD) ? mras_pkg::LK_PRE :
                              mras_pkg::LK_PHY;
            end
         end
         mras_pkg::LK_PHY: begin
            link_next.sh = shIn;
            link_next.bitCnt = link_reg.bitCnt - 5'h01;
            if (link_reg.bitCnt == '0) begin
               link_next.phy = shIn[4:0];
               link_next.bitCnt = mras_pkg::FIELD_LAST;
               link_next.st = mras_pkg::LK_REG;
            end
         end
         mras_pkg::LK_REG: begin
            link_next.sh = shIn;
            link_next.bitCnt = link_reg.bitCnt - 5'h01;
            if (link_reg.bitCnt == '0) begin
               link_next.hit = frameHit;
               link_next.cmd.isCfg = cfgOp;
               link_next.cmd.write = !rdOp;
               link_next.cmd.phyAddrField = link_reg.phy;
               link_next.cmd.regAddr = frameAddr;
               link_next.cmd.wdata = '0;
               if (rdOp) begin
                  // reads that hit ask the core now, two bit times before the data goes out
                  link_next.reqTgl = link_reg.reqTgl ^ frameHit;
                  link_next.st = mras_pkg::LK_TA_RD1;
               end else begin
                  link_next.bitCnt = mras_pkg::TA_LAST;
                  link_next.st = mras_pkg::LK_TA_WR;
               end
            end
         end
         mras_pkg::LK_TA_RD1: begin
            // host has released the line; take it for the second turnaround bit
            link_next.mdioOe = 1'h1;
            link_next.mdioOut = 1'h0;
            link_next.st = mras_pkg::LK_TA_RD2;
         end
         mras_pkg::LK_TA_RD2: begin
            link_next.mdioOut = rdWord[mras_pkg::DATA_W-1];
            link_next.sh = {rdWord[mras_pkg::DATA_W-2:0], 1'h0};
            link_next.bitCnt = mras_pkg::DATA_LAST;
            link_next.st = mras_pkg::LK_RD;
         end
         mras_pkg::LK_RD: begin
            if (link_reg.bitCnt == '0) begin
               link_next.mdioOe = 1'h0;
               link_next.mdioOut = 1'h0;
               link_next.preCnt = '0;
               link_next.st = mras_pkg::LK_PRE;
            end else begin
               link_next.mdioOut = link_reg.sh[mras_pkg::DATA_W-1];
               link_next.sh = {link_reg.sh[mras_pkg::DATA_W-2:0], 1'h0};
               link_next.bitCnt = link_reg.bitCnt - 5'h01;
            end
         end
         mras_pkg::LK_TA_WR: begin
            link_next.ta = taWord;
            link_next.bitCnt = link_reg.bitCnt - 5'h01;
            if (link_reg.bitCnt == '0) begin
               link_next.bitCnt = mras_pkg::DATA_LAST;
               link_next.st = mras_pkg::LK_WR;
            end
         end
         mras_pkg::LK_WR: begin
            link_next.sh = shIn;
            link_next.bitCnt = link_reg.bitCnt - 5'h01;
            if (link_reg.bitCnt == '0) begin
               // a bad turnaround marks a broken frame; the write is dropped
               if (link_reg.hit && (link_reg.ta == mras_pkg::TA_WRITE)) begin
                  link_next.cmd.wdata = link_reg.cmd.isCfg ?
                     {{(mras_pkg::DATA_W-mras_pkg::CFG_DATA_W){1'h0}},
                      shIn[mras_pkg::CFG_DATA_W-1:0]} : shIn;
                  link_next.reqTgl = !link_reg.reqTgl;
               end
               link_next.preCnt = '0;
               link_next.st = mras_pkg::LK_PRE;
            end
         end
      endcase
   end

   // every link flop runs on the rising edge only
   always_ff @(posedge mdcClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         link_reg <= '0;
      end else begin
         link_reg <= link_next;
      end
   end

   assign mdioOut = link_reg.mdioOut;
   assign mdioOe = link_reg.mdioOe;

   // ****************************************************************
   // core domain: request hand-over and read answer
   // ****************************************************************
   mras_sync #(.W(1)) u_req_sync (
      .clk(core_clk),
      .rst_n(reset_n),
      .d(link_reg.reqTgl),
      .q(reqSync)
   );

   assign reqEdge = (reqSync != core_reg.seen);

   always_comb begin
      core_next = core_reg;
      core_next.cmdValid = 1'h0;
      if (reqEdge) begin
         core_next.seen = reqSync;
         // link cmd is held still until the next frame, long after this
         core_next.cmd = link_reg.cmd;
         core_next.cmdValid = 1'h1;
         core_next.rdHold = '0;
         core_next.waiting = !link_reg.cmd.write;
         core_next.waitCnt = mras_pkg::ANSWER_CNT;
      end else if (core_reg.waiting) begin
         if (rdValid) begin
            core_next.rdHold = core_reg.cmd.isCfg ?
               {{(mras_pkg::DATA_W-mras_pkg::CFG_DATA_W){1'h0}},
                rdData[mras_pkg::CFG_DATA_W-1:0]} : rdData;
            core_next.waiting = 1'h0;
         end else if (core_reg.waitCnt == '0) begin
            // a late answer would reach the pin torn; zero is sent instead
            core_next.waiting = 1'h0;
         end else begin
            core_next.waitCnt = core_reg.waitCnt - 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   assign cmdValid = core_reg.cmdValid;
   assign cmd = core_reg.cmd;

endmodule

// File: tb/mras_slave_properties.sv
// concurrent checks on the ports of the management frame slave
`timescale 1ns/100ps
module mras_slave_properties (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic mdcClk,
   input wire logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic cmdValid,
   input wire mras_pkg::mras_cmd_t cmd,
   input wire logic rdValid,
   input wire logic [mras_pkg::DATA_W-1:0] rdData
);
   // ****************************************************************
   // line history: start, opcode and phy bit 4 seen before the answer
   // ****************************************************************
   logic [14:0] hist_reg;
   always_ff @(posedge mdcClk or negedge reset_n) begin
      if (!reset_n) begin
         hist_reg <= 15'h0000;
      end else begin
         hist_reg <= {hist_reg[13:0], mdioIn};
      end
   end
   sequence stdReadHead;
      hist_reg[14:11] == 4'h6;
   endsequence
   sequence cfgReadHead;
      hist_reg[14:10] == 5'h09;
   endsequence
   a_read_cause: assert property (@(posedge mdcClk) disable iff (!reset_n)
      $rose(mdioOe) |-> stdReadHead or cfgReadHead) else $error("drive without read frame");
   a_ta_zero: assert property (@(posedge mdcClk) disable iff (!reset_n)
      $rose(mdioOe) |-> !mdioOut) else $error("turnaround bit not zero");
   a_oe_span: assert property (@(posedge mdcClk) disable iff (!reset_n)
      $rose(mdioOe) |-> ##16 mdioOe ##1 !mdioOe) else $error("drive span wrong");
   a_cfg_upper: assert property (@(posedge mdcClk) disable iff (!reset_n)
      $rose(mdioOe) ##0 cfgReadHead |=> !mdioOut [*8]) else $error("upper byte not zero");
   a_cfg_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdValid && cmd.isCfg |-> cmd.regAddr[7:5] == cmd.phyAddrField[2:0])
      else $error("config address wrong");
   a_cfg_range: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdValid && cmd.isCfg |-> cmd.regAddr <= mras_pkg::CFG_ADDR_MAX)
      else $error("config address out of range");
   a_cfg_dir: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdValid && cmd.isCfg |-> cmd.write == !cmd.phyAddrField[4])
      else $error("config direction wrong");
   a_cfg_wdata: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdValid && cmd.isCfg && cmd.write |-> cmd.wdata[15:8] == 8'h00)
      else $error("config upper write byte kept");
   a_std_regs: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdValid && !cmd.isCfg |-> cmd.regAddr inside {[8'h00:8'h05], 8'h1d, 8'h1f})
      else $error("unsupported register requested");
endmodule
bind mras_slave mras_slave_properties chk (.core_clk(core_clk), .reset_n(reset_n),
   .mdcClk(mdcClk), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
   .cmdValid(cmdValid), .cmd(cmd), .rdValid(rdValid), .rdData(rdData));

// File: tb/mras_host_model.sv
// host controller model: management clock and the host half of the data line
`timescale 1ns/100ps
module mras_host_model (
   output logic mdcClk,
   output logic hostOut,
   output logic hostOe,
   input wire logic mdio
);
   initial begin
      mdcClk = 1'h0;
      hostOut = 1'h1;
      hostOe = 1'h0;
   end
   // ****************************************************************
   // one frame; clock stands still between frames
   // ****************************************************************
   // two idle edges lead so the link leaves reset before the preamble
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
         input logic [1:0] ta, input logic [15:0] wd, input logic rd, output logic [16:0] got);
      logic [66:0] v;
      v = {2'h3, 32'hffffffff, 2'h1, op, phy, rg, ta, wd, 1'h1};
      got = 17'h00000;
      for (int i = 66; i >= 0; i--) begin
         hostOut = v[i];
         hostOe = i > 0 && i < 65 && !(rd && i < 19);
         #62.5;
         if (i > 0 && i < 18) begin
            got[i-1] = mdio;
         end
         mdcClk = 1'h1;
         #62.5;
         mdcClk = 1'h0;
      end
   endtask
endmodule

// File: tb/mras_slave_test.sv
// self-checking bench of the management frame slave
`timescale 1ns/100ps
module mras_slave_test;
   logic core_clk, reset_n, mdcClk, hostOut, hostOe, mdioOut, mdioOe, cmdValid, rdValid;
   logic [15:0] rdData;
   mras_pkg::mras_cmd_t cmd, lastCmd;
   wire logic mdio;
   logic [7:0] cfgMem [256];
   logic [15:0] stdMem [32];
   int errors = 0;
   int nTests = 0;
   int nCmd = 0;
   // pull-up on the shared line
   assign mdio = mdioOe ? mdioOut : (hostOe ? hostOut : 1'h1);
   mras_host_model host (.mdcClk(mdcClk), .hostOut(hostOut), .hostOe(hostOe), .mdio(mdio));
   mras_slave dut (.core_clk(core_clk), .reset_n(reset_n), .mdcClk(mdcClk), .mdioIn(mdio),
      .mdioOut(mdioOut), .mdioOe(mdioOe), .cmdValid(cmdValid), .cmd(cmd), .rdValid(rdValid),
      .rdData(rdData));
   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ****************************************************************
   // user side: answers reads at once, junk in the upper config byte
   // ****************************************************************
   always @(posedge core_clk) begin
      rdValid <= 1'h0;
      if (cmdValid === 1'h1) begin
         nCmd <= nCmd + 1;
         lastCmd <= cmd;
         rdValid <= !cmd.write;
         rdData <= cmd.isCfg ? {8'hff, cfgMem[cmd.regAddr]} : stdMem[cmd.regAddr[4:0]];
         if (cmd.write && cmd.isCfg) begin
            cfgMem[cmd.regAddr] <= cmd.wdata[7:0];
         end
         if (cmd.write && !cmd.isCfg) begin
            stdMem[cmd.regAddr[4:0]] <= cmd.wdata;
         end
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
         input logic [1:0] ta, input logic [15:0] wd, input logic rd, output logic [16:0] got,
         output int n);
      int n0;
      n0 = nCmd;
      host.frame(op, phy, rg, ta, wd, rd, got);
      repeat (8) @(posedge core_clk);
      n = nCmd - n0;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic stdRegs;
      logic [4:0] regs [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1d, 5'h1f, 5'h06, 5'h1e};
      logic [16:0] got;
      int n;
      for (int k = 0; k < 10; k++) begin
         xfer(2'h1, 5'h03, regs[k], 2'h2, {8'hc3, 3'h0, regs[k]}, 1'h0, got, n);
         check(32'(n), 32'(k < 8));
         if (k < 8) begin
            check(32'(lastCmd), {3'h1, 5'h03, 3'h0, regs[k], 8'hc3, 3'h0, regs[k]});
         end
         xfer(2'h2, 5'h03, regs[k], 2'h3, 16'h0000, 1'h1, got, n);
         check(got, k < 8 ? {9'h0c3, 3'h0, regs[k]} : 17'h00000);
         check({mdioOe, mdio}, 2'h1);
      end
   endtask
   task automatic cfgAccess;
      logic [16:0] got;
      int n;
      xfer(2'h0, 5'h0b, 5'h05, 2'h2, 16'ha55a, 1'h0, got, n);
      check(32'(lastCmd), {1'h0, 1'h1, 1'h1, 5'h0b, 8'h65, 16'h005a});
      xfer(2'h0, 5'h13, 5'h05, 2'h3, 16'h0000, 1'h1, got, n);
      check(got, 17'h0005a);
      check({lastCmd.write, lastCmd.regAddr}, 9'h065);
      xfer(2'h0, 5'h06, 5'h06, 2'h2, 16'hff77, 1'h0, got, n);
      check(32'(n), 32'h1);
      xfer(2'h0, 5'h1e, 5'h06, 2'h3, 16'h0000, 1'h1, got, n);
      check(got, 17'h00077);
      xfer(2'h0, 5'h06, 5'h07, 2'h2, 16'h0011, 1'h0, got, n);
      check(32'(n), 32'h0);
      xfer(2'h0, 5'h16, 5'h07, 2'h3, 16'h0000, 1'h1, got, n);
      check({15'(n), got}, 32'h00000);
   endtask
   task automatic frameFaults;
      logic [16:0] got;
      int n;
      xfer(2'h1, 5'h03, 5'h01, 2'h3, 16'h1234, 1'h0, got, n);
      check(32'(n), 32'h0);
      xfer(2'h3, 5'h03, 5'h01, 2'h3, 16'h0000, 1'h1, got, n);
      check({15'(n), got}, 32'h1ffff);
   endtask
   task automatic close_out;
      if (errors == 0 && nTests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      errors++;
      close_out();
   end
   initial begin
      // applied late in time zero so every asynchronous clear sees the falling edge
      reset_n <= 1'h0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'h1;
      repeat (4) @(posedge core_clk);
      stdRegs();
      cfgAccess();
      frameFaults();
      close_out();
   end
endmodule
